// ### rtl/eeprom_wr_pkg.sv
// Shared constants and types for the serial EEPROM write-path slave.
// Assumes one system clock at CLK_MHZ and a separate link sampling clock.
package eeprom_wr_pkg;

  // ==========================================================================
  // Field layout
  localparam int unsigned BYTE_W     = 8;     // Bits per byte
  localparam int unsigned ADDR_W     = 8;     // Word address width
  localparam int unsigned PAGE_BITS  = 4;     // Low pointer bits inside a page
  localparam int unsigned PAGE_SIZE  = 16;    // Bytes per page buffer
  localparam int unsigned CODE_W     = 4;     // Control code width
  localparam int unsigned SEL_W      = 3;     // Chip select width
  localparam logic [3:0]  ACK_SLOT   = 4'h8;  // Bit count when byte is complete
  localparam int unsigned HALF_BIT   = 7;     // Address bit clear for lower half

  // ==========================================================================
  // Reset values
  localparam logic        SOFT_RST   = 1'b0;  // Resettable protect after reset
  localparam logic        PERM_RST   = 1'b0;  // Permanent protect of a fresh part

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ    = 100;   // System clock rate
  localparam int unsigned TWC_MS     = 5;     // Write cycle time, ms
  localparam int unsigned TWC_CYCLES = TWC_MS * CLK_MHZ * 1000;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    L_IDLE, L_CTRL, L_ADDR, L_DATA, L_IGNORE
  } link_state_type;

  typedef enum logic [1:0] {
    C_IDLE, C_PROG, C_WAIT
  } core_state_type;

  typedef enum logic [1:0] {
    CMD_PAGE, CMD_SOFT_SET, CMD_SOFT_CLR, CMD_PERM_SET
  } cmd_type;

endpackage : eeprom_wr_pkg

// ### rtl/eeprom_wr_slave.sv
// Two-wire slave write path of a 256-byte EEPROM with page buffer and protection.
// Assumes the bus pins are sampled on linkClk and the array runs on clk.
`timescale 1ns/1ps
`default_nettype none

module eeprom_wr_slave
  import eeprom_wr_pkg::*;
#(
  parameter logic [3:0]  MEM_CODE     = 4'h5,      // Arbitrary value, memory code
  parameter logic [3:0]  PROT_CODE    = 4'h9,      // Arbitrary value, protect code
  parameter int unsigned WRITE_CYCLES = TWC_CYCLES // Busy length, at least 17
) (
  // System clock domain
  input  wire logic              clk,
  input  wire logic              rst,
  // Link sampling clock
  input  wire logic              linkClk,
  // Bus pins
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe_n,
  // Strap pins
  input  wire logic              chipSel0,
  input  wire logic              chipSel1,
  input  wire logic              chipSel2,
  input  wire logic              chipSel0Hv,
  input  wire logic              wpIn,
  // Array observation port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [BYTE_W-1:0] rdData,
  // Status
  output logic                   busy,
  output logic                   softProtect,
  output logic                   permProtect
);

  // ==========================================================================
  // Link domain: reset and pin synchronisers
  logic                 rstMeta_r;     // Reset crossing, first stage
  logic                 linkRst_r;     // Reset in link domain
  logic [7:0]           linkMeta_r;    // Pin crossing, first stage
  logic [7:0]           linkSync_r;    // Pin crossing, second stage
  logic                 sclPrev_r;     // Clock level one sample ago
  logic                 sdaPrev_r;     // Data level one sample ago
  logic                 doneTog_r;     // Completion toggle from core

  // Reset crossing into the link clock
  always_ff @(posedge linkClk) begin
    rstMeta_r <= rst;
    linkRst_r <= rstMeta_r;
  end

  // Two-stage synchroniser for the bus and chip-select pins and the core status; wpIn is synchronised in the core domain
  always_ff @(posedge linkClk) begin
    linkMeta_r <= {sclIn, sdaIn, chipSel2, chipSel1, chipSel0, chipSel0Hv, permProtect, doneTog_r};
    linkSync_r <= linkMeta_r;
  end

  // Edge history of the bus lines
  always_ff @(posedge linkClk) begin
    if (linkRst_r) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= linkSync_r[7];
      sdaPrev_r <= linkSync_r[6];
    end
  end

  // ==========================================================================
  // Link domain: bus conditions and decode
  link_state_type       state_r, state_nxt;     // Protocol state
  logic [3:0]           bitCnt_r, bitCnt_nxt;   // Bits taken in this byte
  logic                 inAck_r, inAck_nxt;     // Inside acknowledge slot
  logic                 ackDrv_r, ackDrv_nxt;   // Pulling data low
  logic [BYTE_W-1:0]    shift_r, shift_nxt;     // Incoming byte
  cmd_type              cmd_r, cmd_nxt;         // Operation held for the core
  logic                 reqTog_r, reqTog_nxt;   // Commit request toggle
  logic [PAGE_BITS-1:0] ptrHi_r, ptrHi_nxt;     // Page part of pointer
  logic [PAGE_BITS-1:0] ptrLo_r, ptrLo_nxt;     // Offset inside the page
  logic                 gotData_r, gotData_nxt; // At least one data byte seen
  logic [PAGE_SIZE-1:0] pageValid_r;            // Buffered entries to commit
  logic [BYTE_W-1:0]    pageBuf_r [PAGE_SIZE];  // Page buffer

  wire logic             sclS    = linkSync_r[7];
  wire logic             sdaS    = linkSync_r[6];
  wire logic [SEL_W-1:0] pinSel  = linkSync_r[5:3];
  wire logic             hvS     = linkSync_r[2];
  wire logic             permS   = linkSync_r[1];
  wire logic             doneS   = linkSync_r[0];
  wire logic             startEv = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  wire logic             stopEv  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
  wire logic             sclRise = sclS & ~sclPrev_r;
  wire logic             sclFall = ~sclS & sclPrev_r;
  wire logic             pend    = reqTog_r ^ doneS;
  wire logic             byteDone = sclFall & (bitCnt_r == ACK_SLOT) & ~inAck_r;
  wire logic [CODE_W-1:0] codeIn = shift_r[7:4];
  wire logic [SEL_W-1:0]  selIn  = shift_r[3:1];
  wire logic              rwIn   = shift_r[0];
  wire logic              memHit = (codeIn == MEM_CODE) & (selIn == pinSel);
  wire logic              protCode = (codeIn == PROT_CODE) & ~rwIn & ~permS;
  wire logic              softHit = protCode & hvS & ~pinSel[2]
                                    & (selIn == {1'b0, pinSel[1], 1'b1});
  wire logic              permHit = protCode & ~hvS & (selIn == pinSel);
  wire logic              ctrlHit = ~pend & (memHit | softHit | permHit);
  wire logic              ackNow  = (state_r == L_CTRL) ? ctrlHit
                                    : ((state_r == L_ADDR) | (state_r == L_DATA)) & ~pend;
  wire logic              bufWe   = byteDone & (state_r == L_DATA);

  // Next-state logic of the protocol engine
  always_comb begin
    state_nxt   = state_r;
    bitCnt_nxt  = bitCnt_r;
    inAck_nxt   = inAck_r;
    ackDrv_nxt  = ackDrv_r;
    shift_nxt   = shift_r;
    cmd_nxt     = cmd_r;
    reqTog_nxt  = reqTog_r;
    ptrHi_nxt   = ptrHi_r;
    ptrLo_nxt   = ptrLo_r;
    gotData_nxt = gotData_r;
    if (startEv) begin
      // Any Start restarts decoding, also a repeated one
      state_nxt   = L_CTRL;
      bitCnt_nxt  = 4'h0;
      inAck_nxt   = 1'b0;
      ackDrv_nxt  = 1'b0;
      gotData_nxt = 1'b0;
    end else if (stopEv) begin
      // Stop ends the frame; a write with data launches the cycle
      state_nxt  = L_IDLE;
      inAck_nxt  = 1'b0;
      ackDrv_nxt = 1'b0;
      if ((state_r == L_DATA) & gotData_r & ~pend) begin
        reqTog_nxt = ~reqTog_r;
      end
    end else if (sclRise & ~inAck_r & (bitCnt_r != ACK_SLOT)
                 & (state_r != L_IDLE) & (state_r != L_IGNORE)) begin
      // Sample one bit per clock pulse while clock goes high
      shift_nxt  = {shift_r[BYTE_W-2:0], sdaS};
      bitCnt_nxt = bitCnt_r + 4'h1;
    end else if (byteDone & (state_r != L_IDLE) & (state_r != L_IGNORE)) begin
      // Byte complete: decide the acknowledge and advance
      inAck_nxt  = 1'b1;
      ackDrv_nxt = ackNow;
      unique case (state_r)
        L_CTRL: begin
          if (!ctrlHit || rwIn) begin
            state_nxt = L_IGNORE;
          end else begin
            state_nxt = L_ADDR;
            cmd_nxt   = memHit ? CMD_PAGE
                      : softHit ? (pinSel[1] ? CMD_SOFT_CLR : CMD_SOFT_SET)
                      : CMD_PERM_SET;
          end
        end
        L_ADDR: begin
          state_nxt = L_DATA;
          ptrHi_nxt = shift_r[7:4];
          ptrLo_nxt = shift_r[3:0];
        end
        L_DATA: begin
          gotData_nxt = 1'b1;
          ptrLo_nxt   = ptrLo_r + 4'h1;
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end else if (sclFall & inAck_r) begin
      // End of the acknowledge pulse: release the line
      inAck_nxt  = 1'b0;
      ackDrv_nxt = 1'b0;
      bitCnt_nxt = 4'h0;
    end
  end

  // Protocol registers
  always_ff @(posedge linkClk) begin
    if (linkRst_r) begin
      state_r   <= L_IDLE;
      bitCnt_r  <= 4'h0;
      inAck_r   <= 1'b0;
      ackDrv_r  <= 1'b0;
      shift_r   <= 8'h00;
      cmd_r     <= CMD_PAGE;
      reqTog_r  <= 1'b0;
      ptrHi_r   <= 4'h0;
      ptrLo_r   <= 4'h0;
      gotData_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      bitCnt_r  <= bitCnt_nxt;
      inAck_r   <= inAck_nxt;
      ackDrv_r  <= ackDrv_nxt;
      shift_r   <= shift_nxt;
      cmd_r     <= cmd_nxt;
      reqTog_r  <= reqTog_nxt;
      ptrHi_r   <= ptrHi_nxt;
      ptrLo_r   <= ptrLo_nxt;
      gotData_r <= gotData_nxt;
    end
  end

  // Valid mask: cleared by the address byte, set per buffered byte
  always_ff @(posedge linkClk) begin
    if (linkRst_r) begin
      pageValid_r <= '0;
    end else if (byteDone & (state_r == L_ADDR)) begin
      pageValid_r <= '0;
    end else if (bufWe) begin
      pageValid_r[ptrLo_r] <= 1'b1;
    end
  end

  // Page buffer; a wrap overwrites the oldest entry
  always_ff @(posedge linkClk) begin
    if (bufWe) begin
      pageBuf_r[ptrLo_r] <= shift_r;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sdaOut  = 1'b0;
  assign sdaOe_n = ~ackDrv_r;

  // ==========================================================================
  // Core domain: crossing, array and write cycle
  logic [1:0]           coreMeta_r;    // Crossing, first stage
  logic [1:0]           coreSync_r;    // Crossing, second stage
  logic                 reqSeen_r;     // Last request toggle handled
  core_state_type       cstate_r;      // Write cycle state
  logic [PAGE_BITS-1:0] idx_r;         // Entry being programmed
  logic [31:0]          timer_r;       // Cycles since launch
  logic                 soft_r;        // Resettable lower-half protect
  logic                 perm_r;        // Permanent lower-half protect
  logic [BYTE_W-1:0]    mem_r [1 << ADDR_W]; // Array
  logic [BYTE_W-1:0]    rdData_r;      // Observation read data

  wire logic              wpS      = coreSync_r[1];
  wire logic              reqEv    = coreSync_r[0] ^ reqSeen_r;
  wire logic [ADDR_W-1:0] memAddr  = {ptrHi_r, idx_r};
  wire logic              lowHalf  = ~memAddr[HALF_BIT];
  wire logic              allowed  = ~wpS & ~(lowHalf & (soft_r | perm_r));
  wire logic              memWe    = (cstate_r == C_PROG) & pageValid_r[idx_r] & allowed;
  wire logic              timerEnd = (timer_r == WRITE_CYCLES - 32'd1);

  // Synchroniser for the protect pin and the request toggle
  always_ff @(posedge clk) begin
    coreMeta_r <= {wpIn, reqTog_r};
    coreSync_r <= coreMeta_r;
  end

  // Write cycle sequencer and protection state
  always_ff @(posedge clk) begin
    if (rst) begin
      cstate_r  <= C_IDLE;
      reqSeen_r <= 1'b0;
      doneTog_r <= 1'b0;
      idx_r     <= 4'h0;
      timer_r   <= 32'h0;
      soft_r    <= SOFT_RST;
      perm_r    <= PERM_RST;
    end else begin
      unique case (cstate_r)
        C_IDLE: begin
          timer_r <= 32'h0;
          idx_r   <= 4'h0;
          if (reqEv) begin
            reqSeen_r <= coreSync_r[0];
            // Protect commands take effect, then wait out the cycle
            unique case (cmd_r)
              CMD_PAGE:     cstate_r <= C_PROG;
              CMD_SOFT_SET: begin soft_r <= 1'b1; cstate_r <= C_WAIT; end
              CMD_SOFT_CLR: begin soft_r <= 1'b0; cstate_r <= C_WAIT; end
              CMD_PERM_SET: begin perm_r <= 1'b1; cstate_r <= C_WAIT; end
            endcase
          end
        end
        C_PROG: begin
          // Walk all sixteen entries, one per cycle
          timer_r <= timer_r + 32'd1;
          idx_r   <= idx_r + 4'h1;
          if (idx_r == 4'hf) begin
            cstate_r <= C_WAIT;
          end
        end
        C_WAIT: begin
          // Full busy period even when nothing was written
          timer_r <= timer_r + 32'd1;
          if (timerEnd) begin
            cstate_r  <= C_IDLE;
            doneTog_r <= ~doneTog_r;
          end
        end
      endcase
    end
  end

  // Array write and observation read
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem_r[memAddr] <= pageBuf_r[idx_r];
    end
    rdData_r <= mem_r[rdAddr];
  end

  assign rdData      = rdData_r;
  assign busy        = (cstate_r != C_IDLE);
  assign softProtect = soft_r;
  assign permProtect = perm_r;

  // ==========================================================================
  // Checks
  chk_start_decode: assert property (@(posedge linkClk) disable iff (linkRst_r)
    startEv |=> (state_r == L_CTRL) && (bitCnt_r == 4'h0))
    else $error("Start did not restart control decode");

  chk_stop_release: assert property (@(posedge linkClk) disable iff (linkRst_r)
    stopEv |=> (state_r == L_IDLE) && sdaOe_n)
    else $error("Stop did not idle and release the line");

  chk_ack_when_idle: assert property (@(posedge linkClk) disable iff (linkRst_r)
    $rose(ackDrv_r) |-> !$past(pend))
    else $error("Acknowledge given while programming");

  chk_ack_stable_high: assert property (@(posedge linkClk) disable iff (linkRst_r)
    $changed(ackDrv_r) |-> !$past(sclS) || $past(startEv) || $past(stopEv))
    else $error("Acknowledge drive changed while clock high");

  chk_mismatch_quiet: assert property (@(posedge linkClk) disable iff (linkRst_r)
    (byteDone && state_r == L_CTRL && !ctrlHit) |=> !ackDrv_r && (state_r == L_IGNORE))
    else $error("Unmatched control byte was acknowledged");

  chk_page_wrap: assert property (@(posedge linkClk) disable iff (linkRst_r)
    (bufWe && !startEv && !stopEv) |=> $stable(ptrHi_r) && (ptrLo_r == $past(ptrLo_r) + 4'h1))
    else $error("Pointer left the page or failed to step");

  chk_commit_on_stop: assert property (@(posedge linkClk) disable iff (linkRst_r)
    $changed(reqTog_r) |-> $past(stopEv) && $past(gotData_r))
    else $error("Write cycle launched without Stop after data");

  chk_wp_blocks: assert property (@(posedge clk) disable iff (rst)
    memWe |-> !wpS)
    else $error("Array written while protect pin high");

  chk_low_half: assert property (@(posedge clk) disable iff (rst)
    (memWe && !memAddr[HALF_BIT]) |-> !soft_r && !perm_r)
    else $error("Protected lower half written");

  chk_perm_sticky: assert property (@(posedge clk) disable iff (rst)
    perm_r |=> perm_r)
    else $error("Permanent protect was cleared");

  chk_busy_length: assert property (@(posedge clk) disable iff (rst)
    (busy && timerEnd && cstate_r == C_WAIT) |=> !busy && $changed(doneTog_r))
    else $error("Busy period did not end on its count");

  chk_ignore_quiet: assert property (@(posedge linkClk) disable iff (linkRst_r)
    (state_r == L_IGNORE && !inAck_r) |-> !ackDrv_r)
    else $error("Line pulled low while ignoring the frame");

  chk_buf_clear: assert property (@(posedge linkClk) disable iff (linkRst_r)
    (byteDone && state_r == L_ADDR) |=> (pageValid_r == '0))
    else $error("Page buffer kept entries of an earlier frame");

  chk_launch_busy: assert property (@(posedge clk) disable iff (rst)
    reqEv |-> (cstate_r == C_IDLE) ##1 busy)
    else $error("Write request lost or taken mid cycle");

endmodule : eeprom_wr_slave

`default_nettype wire

// ### sim/twi_master_model.sv
// Two-wire bus master model that drives the bus clock and the master's side of the data wire.
// Assumes the bench resolves the data wire with a pull-up and feeds the level back on busData.
`timescale 1ns/1ps
`default_nettype none

module twi_master_model #(
  parameter int HALF = 20  // System clocks per bus clock phase
) (
  // Timing reference
  input  wire logic clk,
  // Bus wires
  input  wire logic busData,
  output logic      sclOut,
  output logic      sdaDrv
);
  // ==========================================================================
  // Idle bus at power-up
  initial begin
    sclOut = 1'b1;  // Clock high, stands still between frames
    sdaDrv = 1'b1;  // Data released
  end

  // One bus clock phase, changes land just after a clk edge
  task automatic phase();
    repeat (HALF) @(posedge clk);
  endtask : phase

  // Start or repeated Start, entered from idle or with clock low
  task automatic startCond();
    sdaDrv <= 1'b1;
    phase();
    sclOut <= 1'b1;
    phase();
    sdaDrv <= 1'b0;
    phase();
    sclOut <= 1'b0;
    phase();
  endtask : startCond

  // Stop, entered with clock low
  task automatic stopCond();
    sdaDrv <= 1'b0;
    phase();
    sclOut <= 1'b1;
    phase();
    sdaDrv <= 1'b1;
    phase();
  endtask : stopCond

  // Eight bits MSB first, then an extra pulse for the acknowledge
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic hi0;
    for (int i = 7; i >= 0; i--) begin
      sdaDrv <= b[i];
      phase();
      sclOut <= 1'b1;
      phase();
      sclOut <= 1'b0;
      phase();
    end
    sdaDrv <= 1'b1;
    phase();
    sclOut <= 1'b1;
    @(posedge clk);
    hi0 = busData;
    phase();
    ack = !hi0 && !busData;
    sclOut <= 1'b0;
    phase();
  endtask : sendByte
endmodule : twi_master_model
`default_nettype wire

// ### sim/serial_eeprom_bus_slave_write_path_tb.sv
// Self-checking bench for the EEPROM write-path slave, driven by the bus master model.
// Assumes the slave and package under rtl/ and the master model under sim/.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_slave_write_path_tb;
  // ==========================================================================
  // Settings and wires
  localparam int         WC = 1000;  // Shortened write cycle, clk cycles
  localparam logic [3:0] MC = 4'h5;  // Memory code, arbitrary value
  localparam logic [3:0] PC = 4'h9;  // Protect code, arbitrary value
  logic       clk, rst, linkClk, sclIn, sdaIn, sdaOut, sdaOe_n, sdaDrv;  // Clocks and bus
  logic       chipSel0, chipSel1, chipSel2, chipSel0Hv, wpIn;            // Straps
  logic       busy, softProtect, permProtect;                            // Status
  logic [7:0] rdAddr, rdData;                                            // Array port
  logic [7:0] expMem [256];                                              // Expected array
  int         fails, checks_done, busyLen, busyRun, acks;                // Bookkeeping

  assign sdaIn = sdaDrv & (sdaOe_n | sdaOut);  // Pull-up wire, open drain device

  // Clocks, unrelated in phase
  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial #3 linkClk = 1'b0;
  always #7.5 linkClk = ~linkClk;

  eeprom_wr_slave #(.MEM_CODE(MC), .PROT_CODE(PC), .WRITE_CYCLES(WC)) dut_u (
    .clk(clk), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .chipSel0(chipSel0), .chipSel1(chipSel1), .chipSel2(chipSel2),
    .chipSel0Hv(chipSel0Hv), .wpIn(wpIn), .rdAddr(rdAddr), .rdData(rdData), .busy(busy),
    .softProtect(softProtect), .permProtect(permProtect));

  twi_master_model mst_u (.clk(clk), .busData(sdaIn), .sclOut(sclIn), .sdaDrv(sdaDrv));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Strap levels, given time to pass the synchronisers
  task automatic setPins(input logic [2:0] sel, input logic hv, input logic wp);
    {chipSel2, chipSel1, chipSel0} <= sel;
    chipSel0Hv <= hv;
    wpIn <= wp;
    repeat (8) @(posedge clk);
  endtask : setPins

  // Whole write frame; counts acknowledged bytes
  task automatic xfer(input logic [3:0] code, input logic [2:0] sel, input logic [7:0] addr,
                      input int n, input logic [7:0] first);
    logic a;
    acks = 0;
    mst_u.startCond();
    mst_u.sendByte({code, sel, 1'b0}, a);
    acks += int'(a);
    mst_u.sendByte(addr, a);
    acks += int'(a);
    for (int i = 0; i < n; i++) begin
      mst_u.sendByte(first + 8'(i), a);
      acks += int'(a);
    end
    mst_u.stopCond();
  endtask : xfer

  // Expected page contents, pointer wraps in the low nibble
  task automatic commit(input logic [7:0] addr, input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) expMem[{addr[7:4], addr[3:0] + 4'(i)}] = first + 8'(i);
  endtask : commit

  // Length of the latest busy period, one count per clk edge
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busyRun <= busyRun + 1;
    end else if (busyRun != 0) begin
      busyLen <= busyRun;
      busyRun <= 0;
    end
  end

  // Bounded wait for the write cycle to start and to finish
  task automatic waitCycle();
    for (int k = 0; k < 100 && busy !== 1'b1; k++) @(posedge clk);
    for (int k = 0; k < WC + 50 && busy === 1'b1; k++) @(posedge clk);
    repeat (10) @(posedge clk);
  endtask : waitCycle

  // Compare every byte with a known expected value
  task automatic checkMem();
    for (int a = 0; a < 256; a++) begin
      if (expMem[a] !== 8'bx) begin
        rdAddr <= 8'(a);
        repeat (3) @(posedge clk);
        check(rdData, expMem[a]);
      end
    end
  endtask : checkMem

  // ==========================================================================
  // Scenarios
  task automatic t_byte_poll();
    logic a;
    setPins(3'b101, 1'b0, 1'b0);
    xfer(MC, 3'b101, 8'h93, 1, 8'ha5);
    check(acks, 3);
    commit(8'h93, 1, 8'ha5);
    mst_u.startCond();
    mst_u.sendByte({MC, 3'b101, 1'b0}, a);
    check(a, 1'b0);
    check(busy, 1'b1);
    mst_u.stopCond();
    waitCycle();
    mst_u.startCond();
    mst_u.sendByte({MC, 3'b101, 1'b0}, a);
    check(a, 1'b1);
    mst_u.stopCond();
    checkMem();
    $display("t_byte_poll done");
  endtask : t_byte_poll

  task automatic t_page_wrap();
    xfer(MC, 3'b101, 8'hcc, 18, 8'h10);
    check(acks, 20);
    commit(8'hcc, 18, 8'h10);
    waitCycle();
    checkMem();
    $display("t_page_wrap done");
  endtask : t_page_wrap

  task automatic t_mismatch();
    logic a;
    for (int s = 0; s < 8; s++) begin
      if (s != 5) begin
        xfer(MC, 3'(s), 8'h40, 1, 8'h01);
        check(acks, 0);
      end
    end
    xfer(4'h3, 3'b101, 8'h40, 1, 8'h01);
    check(acks, 0);
    check(busy, 1'b0);
    mst_u.startCond();
    mst_u.sendByte({MC, 3'b101, 1'b1}, a);
    check(a, 1'b1);
    mst_u.sendByte(8'h40, a);
    check(a, 1'b0);
    mst_u.stopCond();
    check(busy, 1'b0);
    $display("t_mismatch done");
  endtask : t_mismatch

  task automatic t_hw_protect();
    xfer(MC, 3'b101, 8'hf0, 1, 8'h22);
    commit(8'hf0, 1, 8'h22);
    waitCycle();
    setPins(3'b101, 1'b0, 1'b1);
    xfer(MC, 3'b101, 8'hf0, 1, 8'h11);
    check(acks, 3);
    waitCycle();
    check(busyLen >= WC - 1 && busyLen <= WC + 1, 1'b1);
    setPins(3'b101, 1'b0, 1'b0);
    checkMem();
    $display("t_hw_protect done");
  endtask : t_hw_protect

  task automatic t_soft_protect();
    setPins(3'b001, 1'b1, 1'b0);
    xfer(MC, 3'b001, 8'h10, 1, 8'h33);
    commit(8'h10, 1, 8'h33);
    waitCycle();
    xfer(PC, 3'b001, 8'h00, 1, 8'h00);
    check(acks, 3);
    waitCycle();
    check(softProtect, 1'b1);
    xfer(MC, 3'b001, 8'h10, 1, 8'h44);
    check(acks, 3);
    waitCycle();
    xfer(MC, 3'b001, 8'h90, 1, 8'h66);
    commit(8'h90, 1, 8'h66);
    waitCycle();
    checkMem();
    setPins(3'b011, 1'b1, 1'b0);
    xfer(PC, 3'b011, 8'h00, 1, 8'h00);
    waitCycle();
    check(softProtect, 1'b0);
    xfer(MC, 3'b011, 8'h10, 1, 8'h55);
    commit(8'h10, 1, 8'h55);
    waitCycle();
    checkMem();
    $display("t_soft_protect done");
  endtask : t_soft_protect

  task automatic t_perm_protect();
    setPins(3'b101, 1'b0, 1'b0);
    xfer(PC, 3'b101, 8'h00, 1, 8'h00);
    check(acks, 3);
    waitCycle();
    check(permProtect, 1'b1);
    xfer(MC, 3'b101, 8'h10, 1, 8'h77);
    check(acks, 3);
    waitCycle();
    setPins(3'b011, 1'b1, 1'b0);
    xfer(PC, 3'b011, 8'h00, 1, 8'h00);
    check(acks, 0);
    repeat (20) @(posedge clk);
    check(permProtect, 1'b1);
    checkMem();
    $display("t_perm_protect done");
  endtask : t_perm_protect

  // ==========================================================================
  // Verdict, the one place the run ends
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the expected run length
  initial begin
    #900_000;
    fails++;
    wrap_up();
  end

  // Main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    rst = 1'b1;
    {chipSel2, chipSel1, chipSel0, chipSel0Hv, wpIn} = 5'h14;
    rdAddr = 8'h00;
    foreach (expMem[i]) expMem[i] = 8'bx;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    check({sdaOe_n, busy, softProtect, permProtect}, 4'h8);
    t_byte_poll();
    t_page_wrap();
    t_mismatch();
    t_hw_protect();
    t_soft_protect();
    t_perm_protect();
    wrap_up();
  end
endmodule : serial_eeprom_bus_slave_write_path_tb
`default_nettype wire
